//--- hw/adc_control.sv
// Converter control and result registers with APB slave and interrupt
//
// Behaviour
// - Ten-bit result held across high and low bytes, alignment chosen by format bit.
// - Format 0: high byte gives bits 9..2, low byte 7:6 give bits 1:0.
// - Format 1: high byte 1:0 give bits 9:8, low byte gives bits 7..0.
// - Unused result bit positions always read zero.
// - Converter disabled leaves both result registers unchanged.
// - Writing start 0 then 1 then 0 begins exactly one conversion.
// - Busy flag sets once the start sequence initiates a conversion.
// - Busy flag clears when the conversion completes.
// - Enable bit powers the converter on when one, off when zero.
// - Channel codes 0..7 route analog inputs; codes 8..15 leave input floating.
// - Source field chooses internal signal or the selected external channel.
// - Pins used as converter inputs lose their function and pull-high.
// - Source 001..011 grounds the input; 100 picks quarter supply.
// - Clock field divides system clock by 1 to 128 for codes 0..7.
// - Completion sets the interrupt request flag, raising interrupt when enabled.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "adc_ctrl_map.svh"
module adc_control
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] analog_input_pin_select,
  input wire logic comp_above,
  output logic [9:0] dac_trial,
  output logic converter_power,
  output logic bandgap_enable,
  output logic [7:0] analog_inputs_0_to_7,
  output route_t route,
  output logic [7:0] pin_function_disable,
  output logic [7:0] pull_high_disconnect,
  output logic irq
);
  logic [7:0] control_0_q;
  control_1_t control_1_q;
  logic [7:0] bandgap_q;
  logic [9:0] result_q;
  logic busy_q;
  logic start_armed_q;
  logic go;
  logic done;
  logic tick;
  logic [9:0] trial;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  logic enabled;
  source_t source_sel;

  assign wr_en = psel && penable && pwrite && ce;
  assign rd_en = psel && penable && !pwrite && ce;
  assign wbyte = pwdata[7:0];
  assign enabled = control_0_q[`BIT_ENABLE];

  // Gate and route both follow this decode, so they change on the same edge
  always_comb
  begin
    unique case (control_1_q.input_source_select)
      3'b000, 3'b101, 3'b110, 3'b111:
        source_sel = src_external;
      3'b100:
        source_sel = src_quarter_supply;
      3'b001, 3'b010, 3'b011:
        source_sel = src_ground;
    endcase
  end

  // Start fires on the falling write of the start bit after it was seen high
  assign go = wr_en && paddr == `OFS_CONTROL_0 && start_armed_q && !wbyte[`BIT_START]
              && enabled && !busy_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_armed_q <= 1'b0;
    else if (wr_en && paddr == `OFS_CONTROL_0)
      start_armed_q <= wbyte[`BIT_START] && !control_0_q[`BIT_START];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_0_q <= `RESET_CONTROL_0;
      control_1_q <= `RESET_CONTROL_1;
      bandgap_q <= `RESET_BANDGAP;
      irq_mask_q <= 8'h00;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `OFS_CONTROL_0:
          control_0_q <= {wbyte[7], 1'b0, wbyte[5:0]};
        `OFS_CONTROL_1:
          control_1_q <= wbyte;
        `OFS_BANDGAP:
          bandgap_q <= {4'h0, wbyte[`BIT_BANDGAP_EN], 3'h0};
        `OFS_IRQ_MASK:
          irq_mask_q <= {7'h00, wbyte[`IRQ_DONE_BIT]};
        default:
          ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_q <= 1'b0;
    else if (ce)
    begin
      if (go)
        busy_q <= 1'b1;
      else if (done || !enabled)
        busy_q <= 1'b0;
    end
  end

  // Result captured only from a finished conversion, so a disabled converter keeps it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_q <= 10'h000;
    else if (ce && done && busy_q && enabled)
      result_q <= trial;
  end

  clock_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(busy_q),
    .div_sel(control_1_q.conversion_clock_divider),
    .tick(tick)
  );

  sar_engine u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .go(go),
    .tick(tick),
    .comp_above(comp_above),
    .trial(trial),
    .done(done)
  );

  always_comb
  begin
    if (control_0_q[`BIT_ALIGN])
    begin
      result_high_byte = {6'h00, result_q[9:8]};
      result_low_byte = result_q[7:0];
    end
    else
    begin
      result_high_byte = result_q[9:2];
      result_low_byte = {result_q[1:0], 6'h00};
    end
  end

  // Read of status clears it, but a completion in the same cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_q <= 8'h00;
    else if (ce)
    begin
      if (done && busy_q)
        irq_status_q[`IRQ_DONE_BIT] <= 1'b1;
      else if (rd_en && paddr == `OFS_IRQ_STATUS)
        irq_status_q <= 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(irq_status_q & irq_mask_q);
  end

  always_comb
  begin
    rd_ok = 1'b1;
    unique case (paddr)
      `OFS_RESULT_LOW:
        rd_byte = result_low_byte;
      `OFS_RESULT_HIGH:
        rd_byte = result_high_byte;
      `OFS_CONTROL_0:
        rd_byte = {control_0_q[7], busy_q, control_0_q[5:0]};
      `OFS_CONTROL_1:
        rd_byte = control_1_q;
      `OFS_BANDGAP:
        rd_byte = bandgap_q;
      `OFS_IRQ_STATUS:
        rd_byte = irq_status_q;
      `OFS_IRQ_MASK:
        rd_byte = irq_mask_q;
      default:
      begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Zero-wait slave: registered answer during the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      if (psel && !penable && !pwrite)
        prdata <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_power <= 1'b0;
      bandgap_enable <= 1'b0;
      dac_trial <= 10'h000;
      analog_inputs_0_to_7 <= 8'h00;
      route <= '0;
      pin_function_disable <= 8'h00;
      pull_high_disconnect <= 8'h00;
    end
    else if (ce)
    begin
      converter_power <= enabled;
      bandgap_enable <= bandgap_q[`BIT_BANDGAP_EN];
      dac_trial <= trial;
      // Analog input gates open only for a legal channel under an external source
      analog_inputs_0_to_7 <= (!control_0_q[3] && source_sel == src_external)
                              ? 8'(8'h01 << control_0_q[2:0]) : 8'h00;
      route.external_channel_select <= control_0_q[3:0];
      route.ext_connected <= !control_0_q[3];
      route.source <= source_sel;
      pin_function_disable <= analog_input_pin_select;
      pull_high_disconnect <= analog_input_pin_select;
    end
  end
endmodule : adc_control

//--- hw/adc_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define OFS_RESULT_LOW 12'h000
`define OFS_RESULT_HIGH 12'h004
`define OFS_CONTROL_0 12'h008
`define OFS_CONTROL_1 12'h00C
`define OFS_BANDGAP 12'h010
`define OFS_IRQ_STATUS 12'h014
`define OFS_IRQ_MASK 12'h018
`define BIT_START 7
`define BIT_BUSY 6
`define BIT_ENABLE 5
`define BIT_ALIGN 4
`define BIT_BANDGAP_EN 3
`define RESET_CONTROL_0 8'h00
`define RESET_CONTROL_1 8'h00
`define RESET_BANDGAP 8'h00
`define CONV_CYCLES 5'd16
`define IRQ_DONE_BIT 0
`endif

//--- hw/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;
  typedef enum logic [1:0] {src_external, src_ground, src_quarter_supply} source_t;
  typedef struct packed {
    logic [2:0] input_source_select;
    logic [1:0] reference_select;
    logic [2:0] conversion_clock_divider;
  } control_1_t;
  typedef struct packed {
    logic [3:0] external_channel_select;
    source_t source;
    logic ext_connected;
  } route_t;
endpackage : adc_ctrl_pkg

//--- hw/clock_divider.sv
// Conversion clock tick generator: divides pclk by a power of two
`timescale 1ns/1ns
module clock_divider
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);
  logic [6:0] count_q;
  logic [6:0] limit;

  assign limit = 7'((8'h01 << div_sel) - 8'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= 7'h00;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      if (!run || count_q >= limit)
      begin
        count_q <= 7'h00;
        tick <= run;
      end
      else
      begin
        count_q <= count_q + 7'h01;
        tick <= 1'b0;
      end
    end
  end
endmodule : clock_divider

//--- hw/sar_engine.sv
// Successive-approximation sequencer: six sampling ticks, then one result bit per conversion clock tick
`timescale 1ns/1ns
`include "adc_ctrl_map.svh"
module sar_engine
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic go,
  input wire logic tick,
  input wire logic comp_above,
  output logic [9:0] trial,
  output logic done
);
  logic [4:0] step_q;
  logic [9:0] sar_q;
  logic [9:0] bit_q;
  logic active_q;
  logic decide;
  logic [9:0] sar_d;
  logic [9:0] bit_d;

  assign decide = ce && !go && active_q && tick && step_q >= 5'd6;

  // Trial leaves as its next value, so the registered DAC code already shows it at the next decision
  always_comb
  begin
    sar_d = sar_q;
    bit_d = bit_q;
    if (ce && go)
    begin
      sar_d = 10'h000;
      bit_d = 10'h200;
    end
    else if (decide)
    begin
      if (comp_above)
        sar_d = sar_q | bit_q;
      bit_d = bit_q >> 1;
    end
  end

  assign trial = sar_d | bit_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_q <= 5'd0;
      sar_q <= 10'h000;
      bit_q <= 10'h000;
      active_q <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (go)
      begin
        active_q <= 1'b1;
        step_q <= 5'd0;
        sar_q <= 10'h000;
        bit_q <= 10'h200;
      end
      else if (active_q && tick)
      begin
        // Sampling ticks first, then ten decision ticks
        sar_q <= sar_d;
        bit_q <= bit_d;
        if (step_q == `CONV_CYCLES - 5'd1)
        begin
          active_q <= 1'b0;
          done <= 1'b1;
        end
        step_q <= step_q + 5'd1;
      end
    end
  end
endmodule : sar_engine

//--- tb/adc_control_asserts.sv
// Port checker for the converter control block
`timescale 1ns/1ns
module adc_control_asserts
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] analog_input_pin_select,
  input wire logic [7:0] analog_inputs_0_to_7,
  input wire route_t route,
  input wire logic [7:0] pin_function_disable,
  input wire logic [7:0] pull_high_disconnect,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_after_setup: assert property (ce && psel && !penable |=> pready)
    else $error("no answer after setup");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_gate_one_hot: assert property ($onehot0(analog_inputs_0_to_7))
    else $error("more than one input gated");
  a_gate_follows_route: assert property (|analog_inputs_0_to_7 |->
    route.source == src_external && analog_inputs_0_to_7 == (8'h01 << route.external_channel_select))
    else $error("input gate disagrees with route");
  a_pin_function_off: assert property ($past(ce) |-> pin_function_disable == $past(analog_input_pin_select))
    else $error("pin function disable lags wrongly");
  a_pull_high_off: assert property (pull_high_disconnect == pin_function_disable)
    else $error("pull high disconnect differs");
  c_slverr: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_gate: cover property (|analog_inputs_0_to_7);
endmodule : adc_control_asserts
bind adc_control adc_control_asserts chk (.pclk, .presetn, .ce, .psel, .penable, .prdata, .pready, .pslverr,
  .analog_input_pin_select, .analog_inputs_0_to_7, .route, .pin_function_disable, .pull_high_disconnect, .irq);

//--- tb/adc_control_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "adc_ctrl_map.svh"
module adc_control_tb
  import adc_ctrl_pkg::*;
;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] pin_sel = 0, rd, gate, pfd, phd;
  logic [9:0] target = 0, dac_trial;
  logic power, bg;
  route_t route;
  int errors = 0, comparisons = 0, n;
  // Ideal comparator so the successive approximation settles on target
  wire comp_above = target >= dac_trial;
  always #5 pclk = ~pclk;
  adc_control uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .analog_input_pin_select(pin_sel), .comp_above, .dac_trial, .converter_power(power),
    .bandgap_enable(bg), .analog_inputs_0_to_7(gate), .route, .pin_function_disable(pfd),
    .pull_high_disconnect(phd), .irq);
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Idle cycle after each transfer so psel is never reassigned in one time step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      chk("pready", 16'h0001, {15'h0000, pready});
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic convert(input logic [7:0] c0, input logic busy);
    xfer(1, `OFS_CONTROL_0, c0 | 8'h80);
    xfer(1, `OFS_CONTROL_0, c0);
    xfer(0, `OFS_CONTROL_0, 8'h00);
    chk("busy", {15'h0000, busy}, {15'h0000, rd[6]});
    n = 0;
    while (rd[6] && n < 1000)
    begin
      xfer(0, `OFS_CONTROL_0, 8'h00);
      n++;
    end
    chk("busy end", 16'h0000, {15'h0000, rd[6]});
  endtask : convert
  task automatic rd_result(input logic [7:0] eh, input logic [7:0] el);
    xfer(0, `OFS_RESULT_HIGH, 8'h00);
    chk("result high", {8'h00, eh}, {8'h00, rd});
    xfer(0, `OFS_RESULT_LOW, 8'h00);
    chk("result low", {8'h00, el}, {8'h00, rd});
  endtask : rd_result
  task automatic t_reset();
    xfer(0, `OFS_CONTROL_0, 8'h00);
    chk("control 0", 16'h0000, {8'h00, rd});
    xfer(0, `OFS_CONTROL_1, 8'h00);
    chk("control 1", 16'h0000, {8'h00, rd});
    xfer(1, 12'h01C, 8'hFF);
    chk("pslverr", 16'h0001, {15'h0000, err});
  endtask : t_reset
  task automatic t_convert();
    target = 10'h2A5;
    xfer(1, `OFS_CONTROL_1, 8'h00);
    convert(8'h20, 1'b1);
    chk("fast", 16'h0001, {15'h0000, n < 10});
    rd_result(8'hA9, 8'h40);
    xfer(1, `OFS_CONTROL_0, 8'h30);
    rd_result(8'h02, 8'hA5);
  endtask : t_convert
  task automatic t_disabled();
    target = 10'h13C;
    xfer(1, `OFS_CONTROL_1, 8'h07);
    xfer(1, `OFS_CONTROL_0, 8'hB0);
    xfer(1, `OFS_CONTROL_0, 8'h30);
    xfer(0, `OFS_CONTROL_0, 8'h00);
    chk("busy slow", 16'h0001, {15'h0000, rd[6]});
    xfer(1, `OFS_CONTROL_0, 8'h10);
    rd_result(8'h02, 8'hA5);
    convert(8'h10, 1'b0);
    chk("power off", 16'h0000, {15'h0000, power});
    rd_result(8'h02, 8'hA5);
  endtask : t_disabled
  task automatic t_irq();
    xfer(1, `OFS_IRQ_MASK, 8'h01);
    target = 10'h3FF;
    xfer(1, `OFS_CONTROL_1, 8'h03);
    convert(8'h20, 1'b1);
    chk("slow", 16'h0001, {15'h0000, n > 34});
    chk("irq", 16'h0001, {15'h0000, irq});
    xfer(0, `OFS_IRQ_STATUS, 8'h00);
    chk("status", 16'h0001, {8'h00, rd});
    @(posedge pclk);
    chk("irq clear", 16'h0000, {15'h0000, irq});
    xfer(1, `OFS_IRQ_MASK, 8'h00);
    xfer(1, `OFS_CONTROL_1, 8'h00);
    convert(8'h20, 1'b1);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    xfer(0, `OFS_IRQ_STATUS, 8'h00);
  endtask : t_irq
  task automatic t_route();
    source_t e;
    pin_sel <= 8'hA5;
    xfer(1, `OFS_CONTROL_0, 8'h23);
    for (int c = 0; c < 8; c++)
    begin
      xfer(1, `OFS_CONTROL_1, 8'(c << 5));
      @(posedge pclk);
      e = (c == 0 || c > 4) ? src_external : (c == 4) ? src_quarter_supply : src_ground;
      chk("source", {14'h0000, e}, {14'h0000, route.source});
      chk("gate", (e == src_external) ? 16'h0008 : 16'h0000, {8'h00, gate});
    end
    xfer(1, `OFS_CONTROL_0, 8'h2B);
    @(posedge pclk);
    chk("channel", 16'h000B, {12'h000, route.external_channel_select});
    chk("floating", 16'h0000, {15'h0000, route.ext_connected});
    chk("floating gate", 16'h0000, {8'h00, gate});
    chk("pin disable", 16'h00A5, {8'h00, pfd});
    chk("pull high", 16'h00A5, {8'h00, phd});
  endtask : t_route
  task automatic t_power();
    xfer(1, `OFS_BANDGAP, 8'hFF);
    xfer(0, `OFS_BANDGAP, 8'h00);
    chk("bandgap reg", 16'h0008, {8'h00, rd});
    chk("bandgap pin", 16'h0001, {15'h0000, bg});
    chk("power on", 16'h0001, {15'h0000, power});
  endtask : t_power
  // Clock enable low must hold every register, seen here on the pin copy
  task automatic t_freeze();
    ce <= 1'b0;
    pin_sel <= 8'h5A;
    repeat (3) @(posedge pclk);
    chk("frozen", 16'h00A5, {8'h00, pfd});
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("released", 16'h005A, {8'h00, pfd});
  endtask : t_freeze
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_convert();
    t_disabled();
    t_irq();
    t_route();
    t_power();
    t_freeze();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
endmodule : adc_control_tb
